// file: rtl/mac_cfg_pkg.sv
// Constants and types shared by the MAC enable and station address logic
package mac_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0]  CTRL_INDEX       = 4'h1;
    localparam logic [3:0]  ADDR_HIGH_INDEX  = 4'h2;
    localparam logic [3:0]  ADDR_LOW_INDEX   = 4'h3;
    localparam int          INDEX_LSB        = 2;
    localparam int          INDEX_WIDTH      = 4;

    // Control register fields
    localparam int          TX_EN_BIT        = 3;
    localparam int          RX_EN_BIT        = 2;
    localparam int          INIT_DONE_BIT    = 31;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

    // Station address registers
    localparam int          ADDR_HIGH_WIDTH  = 16;
    localparam logic [31:0] ADDR_HIGH_RESET  = 32'h0000_ffff;
    localparam logic [31:0] ADDR_LOW_RESET   = 32'hffff_ffff;

    // EEPROM byte locations of the station address
    localparam logic [7:0]  EE_FIRST_ADDR    = 8'h01;
    localparam logic [7:0]  EE_HIGH_LO_ADDR  = 8'h05;
    localparam logic [7:0]  EE_HIGH_HI_ADDR  = 8'h06;

    typedef enum logic [1:0] {
        LOAD_START = 2'b00,
        LOAD_FETCH = 2'b01,
        LOAD_DONE  = 2'b10
    } load_state_t;
endpackage : mac_cfg_pkg

// file: rtl/station_addr_loader.sv
// Power-on loader that fetches the station address bytes from the EEPROM controller
`timescale 1ns/1ns
module station_addr_loader (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // EEPROM controller
    input  wire logic       ee_present,
    output logic            ee_req,
    output logic [7:0]      ee_addr,
    input  wire logic       ee_ack,
    input  wire logic [7:0] ee_data,
    // Loaded bytes
    output logic            load_valid,
    output logic [7:0]      load_addr,
    output logic [7:0]      load_byte,
    output logic            load_done
);
    typedef struct packed {
        mac_cfg_pkg::load_state_t state;
        logic                     req;
        logic [7:0]               addr;
        logic                     valid;
        logic [7:0]               byte_addr;
        logic [7:0]               data;
        logic                     done;
    } loader_t;

    loader_t cur;
    loader_t next_cur;

    always_comb begin
        next_cur       = cur;
        next_cur.valid = 1'b0;
        unique case (cur.state)
            mac_cfg_pkg::LOAD_START: begin
                // Strap sampled at the first edge after reset release
                if (ee_present) begin // [R5]
                    next_cur.state = mac_cfg_pkg::LOAD_FETCH;
                    next_cur.req   = 1'b1;
                    next_cur.addr  = mac_cfg_pkg::EE_FIRST_ADDR;
                end else begin
                    next_cur.state = mac_cfg_pkg::LOAD_DONE;
                    next_cur.done  = 1'b1;
                end
            end
            mac_cfg_pkg::LOAD_FETCH: begin
                if (ee_ack) begin
                    next_cur.valid     = 1'b1;
                    next_cur.byte_addr = cur.addr;
                    next_cur.data      = ee_data;
                    if (cur.addr == mac_cfg_pkg::EE_HIGH_HI_ADDR) begin
                        next_cur.state = mac_cfg_pkg::LOAD_DONE;
                        next_cur.req   = 1'b0;
                        next_cur.done  = 1'b1;
                    end else begin
                        next_cur.addr = cur.addr + 8'h01;
                    end
                end
            end
            mac_cfg_pkg::LOAD_DONE: begin
                next_cur.req = 1'b0;
            end
            default: begin
                next_cur.state = mac_cfg_pkg::LOAD_DONE;
                next_cur.req   = 1'b0;
                next_cur.done  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign ee_req     = cur.req;
    assign ee_addr    = cur.addr;
    assign load_valid = cur.valid;
    assign load_addr  = cur.byte_addr;
    assign load_byte  = cur.data;
    assign load_done  = cur.done;
endmodule : station_addr_loader

// file: rtl/mac_enable_and_station_addr_high.sv
// MAC transmit/receive enables and station address registers behind an APB slave
// Function
// [R1] With the transmit enable bit 3 set, queued frames are moved from the buffer onto the line.
// [R2] With bit 3 clear, no new frame is started onto the line.
// [R3] Receive enable bit 2 decides whether frames from the internal PHY are accepted.
// [R4] The address-high register holds address bits 47:32 in bits 15:0, with bits 31:16 reserved.
// [R5] The power-on EEPROM load happens only when a programmed EEPROM is detected.
// [R6] EEPROM byte 0x05 loads bits 7:0 and byte 0x06 loads bits 15:8 of the address-high register.
// [R7] The address is undefined until the load ends; host writes are accepted only after that.
// [R8] The address-high register resets to 0x0000ffff.
// [R9] An address-low register holds address bits 31:0, completing the 48-bit address.
// [R10] Reserved address-high bits read zero and ignore writes.
`timescale 1ns/1ns
module mac_enable_and_station_addr_high (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // EEPROM controller
    input  wire logic        ee_present,
    output logic             ee_req,
    output logic [7:0]       ee_addr,
    input  wire logic        ee_ack,
    input  wire logic [7:0]  ee_data,
    // Transmit buffer side
    input  wire logic        tx_buf_valid,
    input  wire logic [7:0]  tx_buf_data,
    input  wire logic        tx_buf_last,
    output logic             tx_buf_ready,
    // Transmit line side
    output logic             tx_line_valid,
    output logic [7:0]       tx_line_data,
    output logic             tx_line_last,
    // Receive from internal PHY
    input  wire logic        phy_rx_valid,
    input  wire logic [7:0]  phy_rx_data,
    input  wire logic        phy_rx_last,
    // Accepted receive frames
    output logic             rx_out_valid,
    output logic [7:0]       rx_out_data,
    output logic             rx_out_last,
    // Configuration seen by the MAC
    output logic [47:0]      station_address,
    output logic             tx_path_enable,
    output logic             rx_path_enable,
    output logic             init_done
);
    typedef struct packed {
        logic        ready;
        logic [31:0] rdata;
        logic        slverr;
        logic        tx_en;
        logic        rx_en;
        logic [15:0] addr_high;
        logic [31:0] addr_low;
        logic        tx_in_frame;
        logic        tx_ready;
        logic        tx_valid;
        logic [7:0]  tx_data;
        logic        tx_last;
        logic        rx_in_frame;
        logic        rx_keep;
        logic        rx_valid;
        logic [7:0]  rx_data;
        logic        rx_last;
    } cfg_t;

    cfg_t       cur;
    cfg_t       next_cur;
    logic       load_valid;
    logic [7:0] load_addr;
    logic [7:0] load_byte;
    logic       load_done;

    station_addr_loader u_station_addr_loader (
        .pclk       (pclk),
        .presetn    (presetn),
        .ee_present (ee_present),
        .ee_req     (ee_req),
        .ee_addr    (ee_addr),
        .ee_ack     (ee_ack),
        .ee_data    (ee_data),
        .load_valid (load_valid),
        .load_addr  (load_addr),
        .load_byte  (load_byte),
        .load_done  (load_done)
    );

    logic [mac_cfg_pkg::INDEX_WIDTH-1:0] index;
    logic                                access;
    logic                                commit;
    logic                                mapped;
    logic [31:0]                         ctrl_view;
    logic                                tx_take;
    logic                                rx_start;
    logic [1:0]                          low_lane;

    assign index  = paddr[mac_cfg_pkg::INDEX_LSB +: mac_cfg_pkg::INDEX_WIDTH];
    assign access = psel && penable;
    assign commit = access && cur.ready;
    assign mapped = (paddr[31:mac_cfg_pkg::INDEX_LSB+mac_cfg_pkg::INDEX_WIDTH] == '0) &&
                    (paddr[1:0] == 2'b00) &&
                    ((index == mac_cfg_pkg::CTRL_INDEX) || (index == mac_cfg_pkg::ADDR_HIGH_INDEX) ||
                     (index == mac_cfg_pkg::ADDR_LOW_INDEX));

    always_comb begin
        ctrl_view                              = '0;
        ctrl_view[mac_cfg_pkg::TX_EN_BIT]      = cur.tx_en;
        ctrl_view[mac_cfg_pkg::RX_EN_BIT]      = cur.rx_en;
        ctrl_view[mac_cfg_pkg::INIT_DONE_BIT]  = load_done;
    end

    assign tx_take  = cur.tx_ready && tx_buf_valid;
    assign rx_start = phy_rx_valid && !cur.rx_in_frame;
    // Byte lane of the low address word; offset from byte 0x01 so the fourth byte lands in lane 3
    assign low_lane = 2'(load_addr - mac_cfg_pkg::EE_FIRST_ADDR);

    always_comb begin
        next_cur          = cur;
        next_cur.ready    = access && !cur.ready;
        next_cur.tx_valid = 1'b0;
        next_cur.rx_valid = 1'b0;

        // Read data captured one cycle into the access phase
        if (access && !cur.ready) begin
            next_cur.slverr = !mapped;
            next_cur.rdata  = '0;
            if (mapped && !pwrite) begin
                unique case (index)
                    mac_cfg_pkg::CTRL_INDEX:      next_cur.rdata = ctrl_view;
                    mac_cfg_pkg::ADDR_HIGH_INDEX: next_cur.rdata = {16'h0000, cur.addr_high}; // [R4] [R10]
                    default:                      next_cur.rdata = cur.addr_low; // [R9]
                endcase
            end
        end

        // EEPROM bytes land in the address registers
        if (load_valid) begin
            unique case (load_addr)
                mac_cfg_pkg::EE_HIGH_LO_ADDR: next_cur.addr_high[7:0]  = load_byte; // [R6]
                mac_cfg_pkg::EE_HIGH_HI_ADDR: next_cur.addr_high[15:8] = load_byte; // [R6]
                default: begin
                    if (load_addr >= mac_cfg_pkg::EE_FIRST_ADDR && load_addr < mac_cfg_pkg::EE_HIGH_LO_ADDR) begin
                        next_cur.addr_low[8*low_lane +: 8] = load_byte; // [R9]
                    end
                end
            endcase
        end

        // Register writes
        if (commit && pwrite && mapped) begin
            unique case (index)
                mac_cfg_pkg::CTRL_INDEX: begin
                    next_cur.tx_en = pwdata[mac_cfg_pkg::TX_EN_BIT];
                    next_cur.rx_en = pwdata[mac_cfg_pkg::RX_EN_BIT];
                end
                mac_cfg_pkg::ADDR_HIGH_INDEX: begin
                    if (load_done) begin // [R7]
                        next_cur.addr_high = pwdata[mac_cfg_pkg::ADDR_HIGH_WIDTH-1:0]; // [R4] [R10]
                    end
                end
                default: begin
                    if (load_done) begin // [R7]
                        next_cur.addr_low = pwdata; // [R9]
                    end
                end
            endcase
        end

        // Transmit path: a frame in progress always finishes
        if (tx_take) begin
            next_cur.tx_valid    = 1'b1; // [R1]
            next_cur.tx_data     = tx_buf_data;
            next_cur.tx_last     = tx_buf_last;
            next_cur.tx_in_frame = !tx_buf_last;
        end
        next_cur.tx_ready = next_cur.tx_en || next_cur.tx_in_frame; // [R1] [R2]

        // Receive path: decision taken on the first byte of each frame
        if (phy_rx_valid) begin
            if (rx_start) begin
                next_cur.rx_keep = cur.rx_en; // [R3]
            end
            next_cur.rx_in_frame = !phy_rx_last;
            next_cur.rx_valid    = rx_start ? cur.rx_en : cur.rx_keep; // [R3]
            next_cur.rx_data     = phy_rx_data;
            next_cur.rx_last     = phy_rx_last;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur           <= '0;
            cur.tx_en     <= mac_cfg_pkg::CTRL_RESET[mac_cfg_pkg::TX_EN_BIT];
            cur.rx_en     <= mac_cfg_pkg::CTRL_RESET[mac_cfg_pkg::RX_EN_BIT];
            cur.addr_high <= mac_cfg_pkg::ADDR_HIGH_RESET[mac_cfg_pkg::ADDR_HIGH_WIDTH-1:0]; // [R8]
            cur.addr_low  <= mac_cfg_pkg::ADDR_LOW_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign pready          = cur.ready;
    assign prdata          = cur.rdata;
    assign pslverr         = cur.slverr;
    assign tx_buf_ready    = cur.tx_ready;
    assign tx_line_valid   = cur.tx_valid;
    assign tx_line_data    = cur.tx_data;
    assign tx_line_last    = cur.tx_last;
    assign rx_out_valid    = cur.rx_valid;
    assign rx_out_data     = cur.rx_data;
    assign rx_out_last     = cur.rx_last;
    assign station_address = {cur.addr_high, cur.addr_low};
    assign tx_path_enable  = cur.tx_en;
    assign rx_path_enable  = cur.rx_en;
    assign init_done       = load_done;
endmodule : mac_enable_and_station_addr_high

// file: verification/mac_cfg_sva.sv
// Port assertions for the MAC enables and station address block
`timescale 1ns/1ns
module mac_cfg_sva (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    // EEPROM controller
    input wire logic        ee_present,
    input wire logic        ee_req,
    input wire logic        ee_ack,
    input wire logic [7:0]  ee_addr,
    input wire logic [7:0]  ee_data,
    // Frame paths and configuration
    input wire logic        tx_buf_valid,
    input wire logic        tx_buf_ready,
    input wire logic        tx_buf_last,
    input wire logic        tx_line_valid,
    input wire logic        phy_rx_valid,
    input wire logic        phy_rx_last,
    input wire logic        rx_out_valid,
    input wire logic [7:0]  tx_buf_data,
    input wire logic [7:0]  tx_line_data,
    input wire logic [47:0] station_address,
    input wire logic        tx_path_enable,
    input wire logic        rx_path_enable,
    input wire logic        init_done
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic tx_busy, rx_busy, rx_keep, rx_kept;
    assign rx_kept = rx_busy ? rx_keep : rx_path_enable;
    // Frame-in-progress trackers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy <= 1'b0;
            rx_busy <= 1'b0;
            rx_keep <= 1'b0;
        end else begin
            if (tx_buf_valid && tx_buf_ready) tx_busy <= !tx_buf_last;
            if (phy_rx_valid) rx_busy <= !phy_rx_last;
            if (phy_rx_valid) rx_keep <= rx_kept;
        end
    end
    a_tx_pass: assert property (
        tx_buf_valid && tx_buf_ready |=> tx_line_valid && tx_line_data == $past(tx_buf_data))
        else $error("accepted tx byte missing on line");
    a_tx_held: assert property (
        !tx_busy && !tx_path_enable |-> !tx_buf_ready)
        else $error("tx buffer taken while disabled");
    a_rx_gate: assert property (
        $past(phy_rx_valid) |-> rx_out_valid == $past(rx_kept))
        else $error("rx byte gating wrong");
    a_high_read: assert property (
        psel && penable && pready && !pwrite && paddr == 32'h8 |-> prdata == {16'h0, $past(station_address[47:32])})
        else $error("address high read wrong");
    a_reset_high: assert property (
        $rose(presetn) |-> station_address == 48'hffff_ffff_ffff)
        else $error("station address reset value wrong");
    a_load_skip: assert property (
        $rose(presetn) && !ee_present |=> init_done && !ee_req ##1 station_address == 48'hffff_ffff_ffff)
        else $error("load not skipped");
    a_byte_six: assert property (
        ee_req && ee_ack && ee_addr == 8'h06 |=> init_done && !ee_req ##1 station_address[47:40] == $past(ee_data, 2))
        else $error("last eeprom byte misplaced");
    a_early_still: assert property (
        !init_done && !$past(ee_ack) |=> $stable(station_address))
        else $error("address changed before load end");
endmodule : mac_cfg_sva

bind mac_enable_and_station_addr_high mac_cfg_sva u_mac_cfg_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .pready, .paddr, .prdata, .ee_present, .ee_req, .ee_ack, .ee_addr, .ee_data, .tx_buf_valid, .tx_buf_ready,
    .tx_buf_last, .tx_line_valid, .phy_rx_valid, .phy_rx_last, .rx_out_valid, .tx_buf_data, .tx_line_data,
    .station_address, .tx_path_enable, .rx_path_enable, .init_done);

// file: verification/ee_ctrl_model.sv
// EEPROM controller model: byte n reads n xor 5a after a set wait
`timescale 1ns/1ns
module ee_ctrl_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Fetch interface
    input  wire logic       ee_req,
    input  wire logic [7:0] ee_addr,
    input  wire logic [3:0] ee_wait,
    output logic            ee_ack,
    output logic [7:0]      ee_data
);
    logic [3:0] count;
    // Data wanders outside the ack cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 4'h0;
            ee_ack <= 1'b0;
            ee_data <= 8'h00;
        end else if (ee_req && !ee_ack && count >= ee_wait) begin
            count <= 4'h0;
            ee_ack <= 1'b1;
            ee_data <= ee_addr ^ 8'h5a;
        end else begin
            count <= ee_req ? count + 4'h1 : 4'h0;
            ee_ack <= 1'b0;
            ee_data <= ~ee_data;
        end
    end
endmodule : ee_ctrl_model

// file: verification/test_mac_enable_and_station_addr_high.sv
// Self-checking bench for the MAC enables and station address block
`timescale 1ns/1ns
module test_mac_enable_and_station_addr_high;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ee_present, ee_req, ee_ack, err;
    logic tx_buf_valid, tx_buf_last, tx_buf_ready, tx_line_valid, tx_line_last, phy_rx_valid, phy_rx_last;
    logic rx_out_valid, rx_out_last, tx_path_enable, rx_path_enable, init_done;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0]  ee_addr, ee_data, tx_buf_data, tx_line_data, phy_rx_data, rx_out_data, txq[$], rxq[$];
    logic [47:0] station_address;
    logic [3:0]  ee_wait;
    int          mismatches = 0, samples_checked = 0, cycles = 0;
    int          tx_ends = 0, rx_ends = 0;

    mac_enable_and_station_addr_high u_mac_enable_and_station_addr_high (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .ee_present, .ee_req, .ee_addr, .ee_ack, .ee_data,
        .tx_buf_valid, .tx_buf_data, .tx_buf_last, .tx_buf_ready, .tx_line_valid, .tx_line_data, .tx_line_last,
        .phy_rx_valid, .phy_rx_data, .phy_rx_last, .rx_out_valid, .rx_out_data, .rx_out_last,
        .station_address, .tx_path_enable, .rx_path_enable, .init_done);
    ee_ctrl_model u_ee_ctrl_model (.pclk, .presetn, .ee_req, .ee_addr, .ee_wait, .ee_ack, .ee_data);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (tx_line_valid) txq.push_back(tx_line_data);
        if (rx_out_valid) rxq.push_back(rx_out_data);
        if (tx_line_valid && tx_line_last) tx_ends++;
        if (rx_out_valid && rx_out_last) rx_ends++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [49:0] seen, input logic [49:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic do_reset(input logic present);
        presetn <= 1'b0;
        ee_present <= present;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset
    task automatic s_load;
        do_reset(1'b1);
        apb(1'b1, 32'h8, 32'h0000_1111);
        chk(init_done, 1'b0);
        for (int i = 0; i < 200 && init_done !== 1'b1; i++) @(posedge pclk);
        @(posedge pclk);
        chk(station_address, 48'h5c5f_5e59_585b);
        apb(1'b0, 32'h8, 32'h0);
        chk({err, rd}, {1'b0, 32'h0000_5c5f});
    endtask : s_load
    task automatic s_regs;
        apb(1'b1, 32'h8, 32'habcd_1234);
        apb(1'b0, 32'h8, 32'h0);
        chk(rd, 32'h0000_1234);
        apb(1'b1, 32'hc, 32'h89ab_cdef);
        @(posedge pclk);
        chk(station_address, 48'h1234_89ab_cdef);
        apb(1'b0, 32'h10, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
    endtask : s_regs
    task automatic s_tx;
        apb(1'b1, 32'h4, 32'h8);
        chk({tx_path_enable, rx_path_enable}, 2'b10);
        for (int i = 0; i < 3; i++) begin
            tx_buf_valid <= 1'b1;
            tx_buf_data <= 8'ha0 + i[7:0];
            tx_buf_last <= (i == 2);
            do @(posedge pclk); while (tx_buf_ready !== 1'b1);
        end
        tx_buf_valid <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({txq.size(), txq[0], txq[2]}, {32'd3, 8'ha0, 8'ha2});
        chk(tx_ends, 1);
        apb(1'b1, 32'h4, 32'h0);
        tx_buf_valid <= 1'b1;
        repeat (10) @(posedge pclk);
        tx_buf_valid <= 1'b0;
        chk({tx_buf_ready, txq.size()}, {1'b0, 32'd3});
    endtask : s_tx
    task automatic rx_frame;
        for (int i = 0; i < 3; i++) begin
            phy_rx_valid <= 1'b1;
            phy_rx_data <= 8'hc0 + i[7:0];
            phy_rx_last <= (i == 2);
            @(posedge pclk);
        end
        phy_rx_valid <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : rx_frame
    task automatic s_rx;
        apb(1'b1, 32'h4, 32'h4);
        apb(1'b0, 32'h4, 32'h0);
        chk({rx_path_enable, rd}, {1'b1, 32'h8000_0004});
        rx_frame();
        apb(1'b1, 32'h4, 32'h0);
        rx_frame();
        chk({rxq.size(), rxq[0], rxq[2]}, {32'd3, 8'hc0, 8'hc2});
        chk(rx_ends, 1);
    endtask : s_rx
    task automatic s_noload;
        do_reset(1'b0);
        repeat (2) @(posedge pclk);
        chk({init_done, ee_req, station_address}, {2'b10, 48'hffff_ffff_ffff});
        apb(1'b0, 32'h8, 32'h0);
        chk(rd, 32'h0000_ffff);
    endtask : s_noload
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ee_present} <= '0;
        {tx_buf_valid, tx_buf_data, tx_buf_last, phy_rx_valid, phy_rx_data, phy_rx_last} <= '0;
        ee_wait <= 4'h3;
        s_load();
        s_regs();
        s_tx();
        s_rx();
        s_noload();
        ee_wait <= 4'h0;
        s_load();
        tally_and_finish();
    end
endmodule : test_mac_enable_and_station_addr_high
